// ---- hdl/wwdt_link_if.sv ----
/*
 wwdt_link_if: signals between the watchdog core, pin evaluator and window checker.
 assumes all three sit on one clock.
*/
`timescale 1ns/1ps

interface wwdt_link_if;
	logic                evalStart;
	logic [1:0]          rstPin;
	logic [1:0]          wdPin;
	logic                evalDone;
	logic [1:0]          rstClass;
	logic [1:0]          wdClass;
	logic                winClear;
	logic                winRun;
	logic                kickFall;
	wwdt_pkg::wwdt_count_t winLower;
	wwdt_pkg::wwdt_count_t winUpper;
	logic                winEarly;
	logic                winLate;

	modport ctrl (output evalStart, rstPin, wdPin, winClear, winRun, kickFall, winLower, winUpper,
		input evalDone, rstClass, wdClass, winEarly, winLate);
	modport eval (input evalStart, rstPin, wdPin, output evalDone, rstClass, wdClass);
	modport win (input winClear, winRun, kickFall, winLower, winUpper, output winEarly, winLate);
endinterface : wwdt_link_if

// ---- hdl/wwdt_pin_eval.sv ----
/*
 wwdt_pin_eval: timed evaluation of the two configuration pins.
 assumes pin classes are sensed by the front end and stable during evaluation.
*/
`timescale 1ns/1ps

module wwdt_pin_eval #(
	parameter wwdt_pkg::wwdt_count_t EVAL_CYCLES = wwdt_pkg::EVAL_CYCLES
) (
	input wire logic    clock,
	input wire logic    rst,
	wwdt_link_if.eval   link
);
	typedef struct packed {
		logic                  busy;
		wwdt_pkg::wwdt_count_t cnt;
		logic                  done;
		logic [1:0][1:0]       cls;
	} wwdt_eval_s;

	wwdt_eval_s      evalReg;
	wwdt_eval_s      evalNext;
	logic [1:0][1:0] pins;
	logic [1:0][1:0] legal;

	assign pins[0] = link.rstPin;
	assign pins[1] = link.wdPin;

	genvar g;
	for (g = 0; g < 2; g++) begin : gClass
		// an undefined sense code falls back to factory open timing
		assign legal[g] = (pins[g] == wwdt_pkg::CFG_CAP || pins[g] == wwdt_pkg::CFG_PULLUP) ?
			pins[g] : wwdt_pkg::CFG_OPEN;
	end

	always_comb begin
		evalNext = evalReg;
		evalNext.done = 1'b0;
		if (link.evalStart) begin
			evalNext.busy = 1'b1;
			evalNext.cnt = '0;
		end else if (evalReg.busy) begin
			if (evalReg.cnt + 32'h1 >= EVAL_CYCLES) begin
				evalNext.busy = 1'b0;
				evalNext.done = 1'b1;
				evalNext.cls = legal;
			end else begin
				evalNext.cnt = evalReg.cnt + 32'h1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			evalReg <= '0;
		end else begin
			evalReg <= evalNext;
		end
	end

	assign link.evalDone = evalReg.done;
	assign link.rstClass = evalReg.cls[0];
	assign link.wdClass = evalReg.cls[1];
endmodule : wwdt_pin_eval

// ---- hdl/wwdt_pkg.sv ----
/*
 wwdt_pkg: constants, timing tables and types of the window watchdog.
 assumes a 125 MHz clock; times are typical figures, counts derive from them.
*/
package wwdt_pkg;
	localparam int unsigned CLK_PERIOD_NS         = 8;
	localparam int unsigned PIN_EVAL_TIME_US      = 381;
	localparam int unsigned ENABLE_SETTLE_TIME_US = 150;
	localparam int unsigned SELECT_CHANGE_GAP_US  = 500;
	localparam int unsigned HOLD_OPEN_TIME_US     = 200000;
	localparam int unsigned HOLD_PULLUP_TIME_US   = 10000;

	localparam int unsigned EVAL_CYCLES   = (PIN_EVAL_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned SETTLE_CYCLES = (ENABLE_SETTLE_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_OPEN_CYCLES   = (HOLD_OPEN_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned HOLD_PULLUP_CYCLES = (HOLD_PULLUP_TIME_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef logic [31:0] wwdt_count_t;
	typedef wwdt_count_t wwdt_table_t [6];

	// index: pin class base (open 0, pull-up 3) plus ratio index
	localparam wwdt_table_t LOWER_BOUND_NS = '{22500000, 1850000, 800000000, 9000000, 9000000, 1850000};
	localparam wwdt_table_t UPPER_BOUND_NS = '{55000000, 27500000, 1600000000, 109000000, 195000000, 11000000};

	function automatic wwdt_table_t wwdt_to_cycles(input wwdt_table_t ns, input logic roundUp);
		wwdt_table_t cyc;
		for (int i = 0; i < 6; i++) begin
			cyc[i] = roundUp ? (ns[i] + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS : ns[i] / CLK_PERIOD_NS;
		end
		return cyc;
	endfunction : wwdt_to_cycles

	localparam wwdt_table_t LOWER_CYCLES = wwdt_to_cycles(LOWER_BOUND_NS, 1'b1);
	localparam wwdt_table_t UPPER_CYCLES = wwdt_to_cycles(UPPER_BOUND_NS, 1'b0);

	localparam logic [1:0] CFG_OPEN   = 2'h0;
	localparam logic [1:0] CFG_PULLUP = 2'h1;
	localparam logic [1:0] CFG_CAP    = 2'h2;
	localparam logic [2:0] TABLE_PULLUP_BASE = 3'h3;

	localparam logic [1:0] RATIO_EIGHTH        = 2'h0;
	localparam logic [1:0] RATIO_THREE_QUARTER = 2'h1;
	localparam logic [1:0] RATIO_HALF          = 2'h2;

	localparam logic [3:0] STATUS_OFFSET  = 4'h0;
	localparam logic [3:0] CONTROL_OFFSET = 4'h4;
	localparam int unsigned STAT_FAULT_BIT  = 0;
	localparam int unsigned STAT_PIN_BIT    = 1;
	localparam int unsigned STAT_ENABLE_BIT = 2;
	localparam int unsigned STAT_PEND_BIT   = 3;
	localparam int unsigned STAT_RATIO_LSB  = 4;
	localparam int unsigned STAT_RCLASS_LSB = 6;
	localparam int unsigned STAT_WCLASS_LSB = 8;
	localparam int unsigned STAT_STATE_LSB  = 10;
	localparam int unsigned CTRL_KICK_BIT   = 0;

	typedef enum logic [3:0] {
		S_OFF,
		S_EVAL,
		S_INIT_HOLD,
		S_IDLE,
		S_SETTLE,
		S_FIRST,
		S_WINDOW,
		S_FAULT,
		S_RECOVER
	} wwdt_state_e;
endpackage : wwdt_pkg

// ---- hdl/wwdt_window_check.sv ----
/*
 wwdt_window_check: interval counter between accepted kicks.
 assumes the core clears it on every accepted kick and outside monitoring.
*/
`timescale 1ns/1ps

module wwdt_window_check (
	input wire logic  clock,
	input wire logic  rst,
	wwdt_link_if.win  link
);
	typedef struct packed {
		wwdt_pkg::wwdt_count_t cnt;
	} wwdt_win_s;

	wwdt_win_s winReg;
	wwdt_win_s winNext;

	always_comb begin
		winNext = winReg;
		if (link.winClear) begin
			winNext.cnt = '0;
		end else if (link.winRun && winReg.cnt != '1) begin
			winNext.cnt = winReg.cnt + 32'h1;
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			winReg <= '0;
		end else begin
			winReg <= winNext;
		end
	end

	assign link.winEarly = link.kickFall && (winReg.cnt < link.winLower);
	assign link.winLate = link.winRun && (winReg.cnt >= link.winUpper);
endmodule : wwdt_window_check

// ---- hdl/wwdt_window_watchdog_timer.sv ----
/*
 wwdt_window_watchdog_timer: window watchdog core with supply sequencing,
 pin evaluation, fault hold, open-drain fault pin and an Avalon-MM status slave.
 assumes supply level, sensed pin classes and capacitor-derived counts come
 from the analog front end, synchronous to clock.
*/
// Decided for this implementation: register access over Avalon-MM and the register offsets.
`timescale 1ns/1ps

module wwdt_window_watchdog_timer #(
	parameter wwdt_pkg::wwdt_count_t EVAL_CYCLES        = wwdt_pkg::EVAL_CYCLES,
	parameter wwdt_pkg::wwdt_count_t SETTLE_CYCLES      = wwdt_pkg::SETTLE_CYCLES,
	parameter wwdt_pkg::wwdt_count_t HOLD_OPEN_CYCLES   = wwdt_pkg::HOLD_OPEN_CYCLES,
	parameter wwdt_pkg::wwdt_count_t HOLD_PULLUP_CYCLES = wwdt_pkg::HOLD_PULLUP_CYCLES,
	parameter wwdt_pkg::wwdt_table_t LOWER_CYCLES       = wwdt_pkg::LOWER_CYCLES,
	parameter wwdt_pkg::wwdt_table_t UPPER_CYCLES       = wwdt_pkg::UPPER_CYCLES
) (
	input  wire logic        clock,
	input  wire logic        rst,
	input  wire logic        supplyOk,
	input  wire logic        kickInput,
	input  wire logic        modeSelect0,
	input  wire logic        modeSelect1,
	input  wire logic [1:0]  resetDelayCfgPin,
	input  wire logic [1:0]  windowTimeCfgPin,
	input  wire logic [31:0] resetCapCycles,
	input  wire logic [31:0] windowCapCycles,
	input  wire logic        faultOutputNIn,
	output logic             faultOutputNOut,
	output logic             faultOutputNOeN,
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest
);
	typedef struct packed {
		wwdt_pkg::wwdt_state_e st;
		wwdt_pkg::wwdt_count_t holdCnt;
		logic                  kickPrev;
		logic                  softKick;
		logic [1:0]            ratio;
		logic                  pendHold;
		logic                  evalStart;
		logic                  oeN;
		logic                  padOut;
		logic                  waitReq;
		logic [31:0]           rdata;
	} wwdt_main_s;

	localparam wwdt_main_s MAIN_RESET = '{
		st:      wwdt_pkg::S_OFF,
		oeN:     1'b1,
		waitReq: 1'b1,
		default: '0
	};

	wwdt_main_s            stateReg;
	wwdt_main_s            stateNext;

	logic                  enabled;
	logic [1:0]            selRatio;
	logic                  kickFall;
	logic                  holdDone;
	logic                  faultNow;
	logic                  winClear;
	logic                  monitoring;
	logic                  holding;
	logic [2:0]            tblIdx;
	wwdt_pkg::wwdt_count_t resetHold;
	wwdt_pkg::wwdt_count_t holdLimit;
	wwdt_pkg::wwdt_count_t lower;
	wwdt_pkg::wwdt_count_t upper;
	logic [31:0]           statusWord;

	wwdt_link_if link ();

	wwdt_pin_eval #(
		.EVAL_CYCLES (EVAL_CYCLES)
	) uPinEval (
		.clock (clock),
		.rst   (rst),
		.link  (link)
	);

	wwdt_window_check uWindow (
		.clock (clock),
		.rst   (rst),
		.link  (link)
	);

	// mode decode and timing selection
	always_comb begin
		enabled = !(modeSelect0 && !modeSelect1);
		if (modeSelect0) begin
			selRatio = wwdt_pkg::RATIO_HALF;
		end else if (modeSelect1) begin
			selRatio = wwdt_pkg::RATIO_THREE_QUARTER;
		end else begin
			selRatio = wwdt_pkg::RATIO_EIGHTH;
		end

		// software kick is treated as one falling edge
		kickFall = (stateReg.kickPrev && !kickInput) || stateReg.softKick;

		case (link.rstClass)
			wwdt_pkg::CFG_CAP:    resetHold = resetCapCycles;
			wwdt_pkg::CFG_PULLUP: resetHold = HOLD_PULLUP_CYCLES;
			default:              resetHold = HOLD_OPEN_CYCLES;
		endcase

		if (stateReg.st == wwdt_pkg::S_SETTLE) begin
			holdLimit = SETTLE_CYCLES;
		end else begin
			holdLimit = resetHold;
		end
		holdDone = (stateReg.holdCnt + 32'h1) >= holdLimit;

		tblIdx = {1'b0, stateReg.ratio};
		if (link.wdClass == wwdt_pkg::CFG_PULLUP) begin
			tblIdx = tblIdx + wwdt_pkg::TABLE_PULLUP_BASE;
		end

		if (link.wdClass == wwdt_pkg::CFG_CAP) begin
			upper = windowCapCycles;
			case (stateReg.ratio)
				wwdt_pkg::RATIO_HALF:          lower = {1'b0, windowCapCycles[31:1]};
				wwdt_pkg::RATIO_THREE_QUARTER: lower = windowCapCycles - {2'h0, windowCapCycles[31:2]};
				default:                       lower = {3'h0, windowCapCycles[31:3]};
			endcase
		end else begin
			upper = UPPER_CYCLES[tblIdx];
			lower = LOWER_CYCLES[tblIdx];
		end

		monitoring = (stateReg.st == wwdt_pkg::S_FIRST) || (stateReg.st == wwdt_pkg::S_WINDOW);
		holding = (stateReg.st == wwdt_pkg::S_FAULT) || (stateReg.st == wwdt_pkg::S_RECOVER);
	end

	// status word seen by software
	always_comb begin
		statusWord = '0;
		statusWord[wwdt_pkg::STAT_FAULT_BIT] = !stateReg.oeN;
		statusWord[wwdt_pkg::STAT_PIN_BIT] = faultOutputNIn;
		statusWord[wwdt_pkg::STAT_ENABLE_BIT] = enabled;
		statusWord[wwdt_pkg::STAT_PEND_BIT] = stateReg.pendHold;
		statusWord[wwdt_pkg::STAT_RATIO_LSB +: 2] = stateReg.ratio;
		statusWord[wwdt_pkg::STAT_RCLASS_LSB +: 2] = link.rstClass;
		statusWord[wwdt_pkg::STAT_WCLASS_LSB +: 2] = link.wdClass;
		statusWord[wwdt_pkg::STAT_STATE_LSB +: 4] = stateReg.st;
	end

	// sequencing state machine and bus slave
	always_comb begin
		stateNext = stateReg;
		stateNext.kickPrev = kickInput;
		stateNext.softKick = 1'b0;
		stateNext.evalStart = 1'b0;
		stateNext.padOut = 1'b0;
		stateNext.holdCnt = stateReg.holdCnt + 32'h1;
		winClear = 1'b1;
		faultNow = 1'b0;

		if (!supplyOk) begin
			// below operating level nothing is monitored
			stateNext.st = wwdt_pkg::S_OFF;
			stateNext.oeN = 1'b1;
			stateNext.pendHold = 1'b0;
			stateNext.holdCnt = '0;
		end else begin
			case (stateReg.st)
				wwdt_pkg::S_OFF: begin
					stateNext.evalStart = 1'b1;
					stateNext.st = wwdt_pkg::S_EVAL;
				end

				wwdt_pkg::S_EVAL: begin
					stateNext.holdCnt = '0;
					if (link.evalDone) begin
						if (enabled) begin
							stateNext.ratio = selRatio;
						end
						stateNext.st = wwdt_pkg::S_INIT_HOLD;
					end
				end

				wwdt_pkg::S_INIT_HOLD: begin
					// pin stays released; kicks count only after this
					if (holdDone) begin
						stateNext.holdCnt = '0;
						stateNext.st = enabled ? wwdt_pkg::S_SETTLE : wwdt_pkg::S_IDLE;
					end
				end

				wwdt_pkg::S_IDLE: begin
					stateNext.holdCnt = '0;
					if (enabled) begin
						// capacitor delay cut short must run again in full
						stateNext.st = stateReg.pendHold ? wwdt_pkg::S_RECOVER : wwdt_pkg::S_SETTLE;
						stateNext.pendHold = 1'b0;
					end
				end

				wwdt_pkg::S_SETTLE: begin
					// kick edges are ignored here
					if (holdDone) begin
						stateNext.st = wwdt_pkg::S_FIRST;
					end
				end

				wwdt_pkg::S_FIRST: begin
					winClear = 1'b0;
					if (kickFall) begin
						winClear = 1'b1;
						stateNext.st = wwdt_pkg::S_WINDOW;
					end else if (link.winLate) begin
						faultNow = 1'b1;
					end
				end

				wwdt_pkg::S_WINDOW: begin
					winClear = 1'b0;
					if (kickFall && link.winEarly) begin
						faultNow = 1'b1;
					end else if (kickFall) begin
						winClear = 1'b1;
					end else if (link.winLate) begin
						faultNow = 1'b1;
					end
				end

				wwdt_pkg::S_FAULT: begin
					// kicks during the hold are ignored
					if (holdDone) begin
						stateNext.oeN = 1'b1;
						stateNext.st = wwdt_pkg::S_FIRST;
					end
				end

				wwdt_pkg::S_RECOVER: begin
					if (holdDone) begin
						stateNext.st = wwdt_pkg::S_FIRST;
					end
				end

				default: begin
					stateNext.st = wwdt_pkg::S_OFF;
				end
			endcase

			if (faultNow) begin
				stateNext.st = wwdt_pkg::S_FAULT;
				stateNext.oeN = 1'b0;
				stateNext.holdCnt = '0;
				stateNext.ratio = selRatio;
			end

			if (!enabled && (monitoring || holding || stateReg.st == wwdt_pkg::S_SETTLE)) begin
				stateNext.st = wwdt_pkg::S_IDLE;
				stateNext.oeN = 1'b1;
				if (holding && link.rstClass == wwdt_pkg::CFG_CAP) begin
					stateNext.pendHold = 1'b1;
				end
			end
		end

		// one wait cycle, then a single-cycle answer
		stateNext.waitReq = 1'b1;
		if ((avs_read || avs_write) && stateReg.waitReq) begin
			stateNext.waitReq = 1'b0;
			stateNext.rdata = '0;
			if (avs_read && avs_address == wwdt_pkg::STATUS_OFFSET) begin
				stateNext.rdata = statusWord;
			end
			if (avs_write && avs_address == wwdt_pkg::CONTROL_OFFSET) begin
				stateNext.softKick = avs_writedata[wwdt_pkg::CTRL_KICK_BIT];
			end
		end
	end

	always_ff @(posedge clock) begin
		if (rst) begin
			stateReg <= MAIN_RESET;
		end else begin
			stateReg <= stateNext;
		end
	end

	assign link.evalStart = stateReg.evalStart;
	assign link.rstPin = resetDelayCfgPin;
	assign link.wdPin = windowTimeCfgPin;
	assign link.winClear = winClear;
	assign link.winRun = monitoring;
	assign link.kickFall = kickFall;
	assign link.winLower = lower;
	assign link.winUpper = upper;

	// open drain: data is always low, only the enable moves
	assign faultOutputNOut = stateReg.padOut;
	assign faultOutputNOeN = stateReg.oeN;
	assign avs_readdata = stateReg.rdata;
	assign avs_waitrequest = stateReg.waitReq;
endmodule : wwdt_window_watchdog_timer

// ---- test/tb_top.sv ----
/*
 tb_top: self-checking bench of the window watchdog top.
 assumes shortened counts: eval 8, settle 6, window 10..40.
*/
`timescale 1ns/1ps

module tb_top;
	localparam int HOLD_O = 20;
	localparam int HOLD_P = 10;
	localparam int CAP_H  = 16;
	localparam wwdt_pkg::wwdt_table_t LOW_T = '{default: 32'hA};
	localparam wwdt_pkg::wwdt_table_t UP_T  = '{default: 32'h28};
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic        supplyOk = 1'b0;
	logic        modeSelect0 = 1'b1;
	logic        modeSelect1 = 1'b0;
	logic [1:0]  resetDelayCfgPin = 2'h0;
	logic [1:0]  windowTimeCfgPin = 2'h0;
	logic [31:0] windowCapCycles = 32'h40;
	logic [3:0]  avs_address = 4'h0;
	logic        avs_read = 1'b0;
	logic        avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic        kickInput;
	logic        faultOutputNOut;
	logic        faultOutputNOeN;
	logic        faultPin;
	int          n_fail = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	// pull-up on the open-drain pin
	assign faultPin = faultOutputNOeN ? 1'b1 : faultOutputNOut;
	always #4 clock = ~clock;
	wwdt_window_watchdog_timer #(.EVAL_CYCLES(8), .SETTLE_CYCLES(6), .HOLD_OPEN_CYCLES(HOLD_O),
		.HOLD_PULLUP_CYCLES(HOLD_P), .LOWER_CYCLES(LOW_T), .UPPER_CYCLES(UP_T)
	) wwdt_window_watchdog_timer_inst (.clock(clock), .rst(rst), .supplyOk(supplyOk),
		.kickInput(kickInput), .modeSelect0(modeSelect0), .modeSelect1(modeSelect1),
		.resetDelayCfgPin(resetDelayCfgPin), .windowTimeCfgPin(windowTimeCfgPin),
		.resetCapCycles(32'(CAP_H)), .windowCapCycles(windowCapCycles),
		.faultOutputNIn(faultPin), .faultOutputNOut(faultOutputNOut),
		.faultOutputNOeN(faultOutputNOeN), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest));
	wwdt_host_model wwdt_host_model_inst (.clock(clock), .kickInput(kickInput));
	task automatic close_out();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : close_out
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			n_fail++;
			$display("timeout");
			close_out();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge clock);
	endtask : tick
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd, output logic [31:0] rd);
		int n;
		n = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clock);
		// no cycle limit here: only the bench timeout ends a hung access
		while (avs_waitrequest !== 1'b0) begin
			@(posedge clock);
			n++;
		end
		check("bus latency", 32'(n), 32'h1);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic chk_status(input int st, input int rc, input int wc, input int ra);
		logic [31:0] v;
		bus(1'b0, 4'h0, 32'h0, v);
		check("state", 32'(v[13:10]), 32'(st));
		if (rc >= 0) check("reset class", 32'(v[7:6]), 32'(rc));
		if (wc >= 0) check("window class", 32'(v[9:8]), 32'(wc));
		if (ra >= 0) check("ratio", 32'(v[5:4]), 32'(ra));
	endtask : chk_status
	function automatic int hold_of(input int rc);
		return rc == 1 ? HOLD_P : (rc == 2 ? CAP_H : HOLD_O);
	endfunction : hold_of
	task automatic power_up(input int rc, input int wc, input logic m0, input logic m1);
		int off;
		off = m0 && !m1;
		supplyOk <= 1'b0;
		// pins and both selects are set here while the supply is down
		resetDelayCfgPin <= 2'(rc);
		windowTimeCfgPin <= 2'(wc);
		modeSelect0 <= m0;
		modeSelect1 <= m1;
		tick(3);
		supplyOk <= 1'b1;
		tick(17 + hold_of(rc));
		chk_status(off ? 3 : 5, rc, wc, off ? -1 : (m1 ? (m0 ? 2 : 1) : 0));
	endtask : power_up
	task automatic wait_low(output int w);
		w = 0;
		while (faultOutputNOeN !== 1'b0 && w < 300) begin
			@(posedge clock);
			w++;
		end
	endtask : wait_low
	task automatic fault_len(output int w, output int lo);
		wait_low(w);
		lo = 0;
		while (faultOutputNOeN === 1'b0 && lo < 300) begin
			@(posedge clock);
			lo++;
		end
	endtask : fault_len
	initial begin
		logic [31:0] rd;
		int w;
		int lo;
		int wc;
		int upT;
		void'($urandom(32'h162F));
		wc = $urandom % 3;
		upT = (wc == 2) ? int'(windowCapCycles) : int'(UP_T[0]);
		tick(12);
		rst <= 1'b0;
		@(posedge clock);
		bus(1'b0, 4'hC, 32'h0, rd);
		check("unmapped read", rd, 32'h0);
		power_up(1, wc, 1'b0, 1'b0);
		repeat (6) begin
			wwdt_host_model_inst.kick(14 + $urandom % 14);
			check("in window", 32'(faultPin), 32'h1);
		end
		chk_status(6, -1, -1, 0);
		// watcher starts before the early kick so the hold count never depends on the low width
		fork
			fault_len(w, lo);
			begin
				wwdt_host_model_inst.kick(2);
				wwdt_host_model_inst.chatter(6);
			end
		join
		check("early hold", 32'(lo), 32'(HOLD_P));
		fault_len(w, lo);
		check("late time", 32'(w >= upT - 2 && w <= upT + 4), 32'h1);
		modeSelect1 <= 1'b1; // one select at a time
		chk_status(5, -1, -1, 0);
		fault_len(w, lo);
		chk_status(5, -1, -1, 1);
		$display("test window done");
		power_up(0, wc, 1'b1, 1'b0);
		fork
			wwdt_host_model_inst.chatter(40);
			bus(1'b1, 4'h4, 32'h1, rd);
		join
		check("disabled", 32'(faultPin), 32'h1);
		modeSelect0 <= 1'b0;
		@(posedge clock);
		chk_status(4, 0, -1, -1);
		tick(8);
		bus(1'b1, 4'h4, 32'h1, rd);
		tick(2);
		chk_status(6, -1, -1, -1);
		power_up(1, wc, 1'b1, 1'b1);
		$display("test modes done");
		for (int rc = 1; rc <= 2; rc++) begin
			power_up(rc, wc, 1'b0, 1'b0);
			wait_low(w);
			tick(3);
			modeSelect0 <= 1'b1;
			tick(2);
			check("disable release", 32'(faultPin), 32'h1);
			bus(1'b0, 4'h0, 32'h0, rd);
			check("pending hold", 32'(rd[3]), 32'(rc == 2));
			check("idle flags", 32'(rd[2:0]), 32'h2);
			modeSelect0 <= 1'b0;
			@(posedge clock);
			chk_status(rc == 2 ? 8 : 4, rc, -1, -1);
		end
		$display("test disable in fault done");
		close_out();
	end
endmodule : tb_top

// ---- test/wwdt_host_model.sv ----
/*
 wwdt_host_model: host that services the watchdog kick pin.
 assumes the bench calls its tasks right after a clock edge.
*/
`timescale 1ns/1ps

module wwdt_host_model (
	input  wire logic clock,
	output logic      kickInput
);
	initial kickInput = 1'b1;
	// falling edge after gap cycles; random low width
	task automatic kick(input int gap);
		int lowLen;
		lowLen = 1 + ($urandom % 3);
		repeat (gap) @(posedge clock);
		kickInput <= 1'b0;
		repeat (lowLen) @(posedge clock);
		kickInput <= 1'b1;
	endtask : kick
	// random wiggle, only used where the pin must be ignored
	task automatic chatter(input int n);
		repeat (n) begin
			@(posedge clock);
			kickInput <= 1'($urandom % 2);
		end
		@(posedge clock);
		kickInput <= 1'b1;
	endtask : chatter
endmodule : wwdt_host_model

// ---- test/wwdt_properties.sv ----
/*
 wwdt_properties: port checks of the window watchdog top.
 assumes config pins stay put while the supply is up.
*/
`timescale 1ns/1ps

module wwdt_properties #(
	parameter wwdt_pkg::wwdt_count_t HOLD_OPEN_CYCLES   = 20,
	parameter wwdt_pkg::wwdt_count_t HOLD_PULLUP_CYCLES = 10
) (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        supplyOk,
	input wire logic        modeSelect0,
	input wire logic        modeSelect1,
	input wire logic [1:0]  resetDelayCfgPin,
	input wire logic [31:0] resetCapCycles,
	input wire logic        faultOutputNOut,
	input wire logic        faultOutputNOeN,
	input wire logic        avs_write,
	input wire logic        avs_waitrequest
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	logic        offMode;
	logic [31:0] expHold;
	logic [31:0] lowRun_reg;
	assign offMode = modeSelect0 && !modeSelect1;
	assign expHold = (resetDelayCfgPin == 2'h1) ? HOLD_PULLUP_CYCLES :
		(resetDelayCfgPin == 2'h2) ? resetCapCycles : HOLD_OPEN_CYCLES;
	always_ff @(posedge clock) begin
		if (rst || faultOutputNOeN) begin
			lowRun_reg <= 32'h0;
		end else begin
			lowRun_reg <= lowRun_reg + 32'h1;
		end
	end
	a_pad_data_low: assert property (faultOutputNOut == 1'b0)
		else $error("fault pad data not low");
	a_off_releases: assert property (!supplyOk |=> faultOutputNOeN)
		else $error("fault held with supply low");
	a_disabled_quiet: assert property (offMode |=> faultOutputNOeN)
		else $error("fault while disabled");
	a_hold_length: assert property ($rose(faultOutputNOeN) && $past(supplyOk) && !$past(offMode)
		|-> lowRun_reg == expHold)
		else $error("fault hold length wrong");
	a_eval_quiet: assert property ($rose(supplyOk) |=> faultOutputNOeN [*8])
		else $error("fault during pin evaluation");
	a_settle_quiet: assert property ($fell(offMode) && supplyOk |=> faultOutputNOeN [*6])
		else $error("fault during enable settling");
	a_wait_one: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low too long");
	a_fault_cause: assert property ($fell(faultOutputNOeN) |-> $past(supplyOk) && !$past(offMode))
		else $error("fault without enabled supply");
	c_fault: cover property ($fell(faultOutputNOeN));
	c_release: cover property ($rose(faultOutputNOeN) && !$past(offMode));
	c_write: cover property ($fell(avs_waitrequest) && $past(avs_write));
endmodule : wwdt_properties

bind wwdt_window_watchdog_timer wwdt_properties #(
	.HOLD_OPEN_CYCLES  (HOLD_OPEN_CYCLES),
	.HOLD_PULLUP_CYCLES(HOLD_PULLUP_CYCLES)
) wwdt_properties_inst (
	.clock           (clock),
	.rst             (rst),
	.supplyOk        (supplyOk),
	.modeSelect0     (modeSelect0),
	.modeSelect1     (modeSelect1),
	.resetDelayCfgPin(resetDelayCfgPin),
	.resetCapCycles  (resetCapCycles),
	.faultOutputNOut (faultOutputNOut),
	.faultOutputNOeN (faultOutputNOeN),
	.avs_write       (avs_write),
	.avs_waitrequest (avs_waitrequest)
);
